// ### hw/uart_fc_consts.vh
`ifndef UART_FC_CONSTS_VH
`define UART_FC_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODEM_LINE_STATE 8'h00
`define OFS_SCRATCH_BYTE 8'h04
`define OFS_EXT_FEATURE 8'h08
`define OFS_INT_MASK 8'h0c
`define OFS_INT_CAUSE 8'h10
`define OFS_QUEUE_CONTROL 8'h14
`define OFS_MODEM_OUT_CONTROL 8'h18
`define OFS_RESUME_FIRST 8'h1c
`define OFS_RESUME_SECOND 8'h20
`define OFS_PAUSE_FIRST 8'h24
`define OFS_PAUSE_SECOND 8'h28
// ****************************************
// Field positions
// ****************************************
`define EFC_AUTO_CTS 7
`define EFC_AUTO_RTS 6
`define EFC_SPECIAL 5
`define EFC_ENHANCED 4
`define CAUSE_SPECIAL 4
`define CAUSE_TRIGGER 5
`define MOC_RTS 1
// ****************************************
// Reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_SCRATCH 8'hff
`define RST_PIN_HIGH 1'b1
// ****************************************
// Receive queue trigger levels
// ****************************************
`define TRIG_LVL0 5'h01
`define TRIG_LVL1 5'h04
`define TRIG_LVL2 5'h08
`define TRIG_LVL3 5'h0e
`define TRIG_FULL 5'h10
// ****************************************
// Flow selection codes
// ****************************************
`define SEL_NONE 2'b00
`define SEL_FIRST 2'b10
`define SEL_SECOND 2'b01
`define SEL_BOTH 2'b11
`endif

// ### hw/sync2.v
`timescale 1ns/100ps
`default_nettype none
`include "uart_fc_consts.vh"
module sync2 (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire [3:0] pin_in,
	output reg [3:0] pin_sync_q
);
	// First stage, read only by the second stage
	reg [3:0] meta_q;
	// ****************************************
	// Two-flop synchroniser, pins idle high
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 4'hf;
			pin_sync_q <= 4'hf;
		end else if (ce) begin
			meta_q <= pin_in;
			pin_sync_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### hw/xchar_match.v
`timescale 1ns/100ps
`default_nettype none
`include "uart_fc_consts.vh"
module xchar_match (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire [1:0] mode,
	input wire [7:0] char_a,
	input wire [7:0] char_b,
	input wire rx_valid,
	input wire [7:0] rx_char,
	output reg match_q
);
	// First character of a pair already seen
	reg half_q;
	// ****************************************
	// Single or paired character compare
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_q <= 1'b0;
			half_q <= 1'b0;
		end else if (ce) begin
			match_q <= 1'b0;
			if (rx_valid) begin
				// Bit 0 of each character register meets the received LSB
				case (mode)
					// Decode of the receive selection
					`SEL_FIRST: match_q <= (rx_char == char_a);
					`SEL_SECOND: match_q <= (rx_char == char_b);
					`SEL_BOTH: begin
						// Pair must arrive back to back
						if (half_q && rx_char == char_b) begin
							match_q <= 1'b1;
							half_q <= 1'b0;
						end else begin
							half_q <= (rx_char == char_a);
						end
					end
					default: half_q <= 1'b0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/uart_flow_control_enhanced.v
`timescale 1ns/100ps
`default_nettype none
`include "uart_fc_consts.vh"
module uart_flow_control_enhanced (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire cts_n,
	input wire dsr_n,
	input wire dcd_n,
	input wire ri_n,
	output reg rts_n,
	input wire rx_valid,
	input wire [7:0] rx_char,
	input wire [4:0] rx_level,
	output reg tx_hold,
	output reg tx_flow_req,
	output reg [7:0] tx_flow_char,
	input wire tx_flow_ack,
	output reg modem_irq,
	output reg rx_trigger_irq,
	output reg special_char_irq
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam ST_IDLE = 3'b001;
	localparam ST_FIRST = 3'b010;
	localparam ST_SECOND = 3'b100;
	// Synchronised pins: 0 cts, 1 dsr, 2 ri, 3 dcd
	wire [3:0] pins_q;
	// Previous pin sample and primed flag
	reg [3:0] prev_q;
	reg primed_q;
	// Delta flags 3:0 of the modem status
	reg [3:0] delta_q;
	reg [7:0] scratch_q;
	reg [7:0] efc_q;
	// Stored copies; bits 7:4, 5:4 and 7:5 are the saved enhanced fields
	reg [7:0] imask_q;
	reg [7:0] qctl_q;
	reg [7:0] moc_q;
	reg [1:0] cause_q;
	reg [7:0] on1_q;
	reg [7:0] on2_q;
	reg [7:0] off1_q;
	reg [7:0] off2_q;
	// Write data phase bookkeeping
	reg wr_pend_q;
	reg [7:0] wr_addr_q;
	// Software flow pause and transmit sender
	reg paused_q;
	reg [2:0] st_q;
	reg send_off_q;
	reg sent_off_q;
	wire on_hit;
	wire off_hit;
	wire enh;
	wire [7:0] line_state_view;
	wire [7:0] imask_view;
	wire [7:0] qctl_view;
	wire [7:0] moc_view;
	wire [7:0] cause_view;
	wire [1:0] trig_sel;
	wire at_trig;
	wire at_next;
	wire below_lower;
	wire addr_ok;
	wire [7:0] aoff;
	wire [1:0] txsel;
	reg [7:0] rd_mux;
	// ****************************************
	// Helpers
	// ****************************************
	// Trigger level by index, index 4 and above is full
	function [4:0] trig_lvl;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: trig_lvl = `TRIG_LVL0;
				3'h1: trig_lvl = `TRIG_LVL1;
				3'h2: trig_lvl = `TRIG_LVL2;
				3'h3: trig_lvl = `TRIG_LVL3;
				default: trig_lvl = `TRIG_FULL;
			endcase
		end
	endfunction
	// Hide the enhanced field when the enhanced bit is low
	function [7:0] gate_hi;
		input [7:0] val;
		input [7:0] hmask;
		input en;
		begin
			gate_hi = en ? val : (val & ~hmask);
		end
	endfunction
	// Merge write data: enhanced field only while unlocked
	function [7:0] merge_wr;
		input [7:0] old;
		input [7:0] wd;
		input [7:0] hmask;
		input en;
		begin
			merge_wr = en ? wd : ((old & hmask) | (wd & ~hmask));
		end
	endfunction
	// ****************************************
	// Submodules
	// ****************************************
	sync2 u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.pin_in({dcd_n, ri_n, dsr_n, cts_n}),
		.pin_sync_q(pins_q)
	);
	xchar_match u_on (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.mode(efc_q[1:0]),
		.char_a(on1_q),
		.char_b(on2_q),
		.rx_valid(rx_valid),
		.rx_char(rx_char),
		.match_q(on_hit)
	);
	xchar_match u_off (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.mode(efc_q[1:0]),
		.char_a(off1_q),
		.char_b(off2_q),
		.rx_valid(rx_valid),
		.rx_char(rx_char),
		.match_q(off_hit)
	);
	// ****************************************
	// Views and decode
	// ****************************************
	assign enh = efc_q[`EFC_ENHANCED];
	// Enhanced fields read zero while locked
	assign imask_view = gate_hi(imask_q, 8'hf0, enh);
	assign qctl_view = gate_hi(qctl_q, 8'h30, enh);
	assign moc_view = gate_hi(moc_q, 8'he0, enh);
	assign cause_view = enh ? {2'b00, cause_q, 4'h0} : 8'h00;
	assign line_state_view = {~pins_q[3], ~pins_q[2], ~pins_q[1], ~pins_q[0], delta_q};
	assign trig_sel = qctl_q[7:6];
	assign at_trig = rx_level >= trig_lvl({1'b0, trig_sel});
	assign at_next = rx_level >= trig_lvl({1'b0, trig_sel} + 3'h1);
	assign below_lower = rx_level < trig_lvl((trig_sel == 2'b00) ? 3'h0 :
		({1'b0, trig_sel} - 3'h1));
	assign addr_ok = hsel && hready && htrans[1];
	assign aoff = haddr[7:0];
	assign txsel = efc_q[3:2];
	// Read multiplexer, unmapped offsets read zero
	always @* begin
		case (aoff)
			`OFS_MODEM_LINE_STATE: rd_mux = line_state_view;
			`OFS_SCRATCH_BYTE: rd_mux = scratch_q;
			`OFS_EXT_FEATURE: rd_mux = efc_q;
			`OFS_INT_MASK: rd_mux = imask_view;
			`OFS_INT_CAUSE: rd_mux = cause_view;
			`OFS_QUEUE_CONTROL: rd_mux = qctl_view;
			`OFS_MODEM_OUT_CONTROL: rd_mux = moc_view;
			`OFS_RESUME_FIRST: rd_mux = on1_q;
			`OFS_RESUME_SECOND: rd_mux = on2_q;
			`OFS_PAUSE_FIRST: rd_mux = off1_q;
			`OFS_PAUSE_SECOND: rd_mux = off2_q;
			default: rd_mux = 8'h00;
		endcase
	end
	// ****************************************
	// Bus slave and register file
	// ****************************************
	// Reads answer with zero wait; writes land at the data phase end
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			scratch_q <= `RST_SCRATCH;
			// Every enhanced control bit starts cleared
			efc_q <= `RST_BYTE;
			imask_q <= `RST_BYTE;
			qctl_q <= `RST_BYTE;
			moc_q <= `RST_BYTE;
			on1_q <= `RST_BYTE;
			on2_q <= `RST_BYTE;
			off1_q <= `RST_BYTE;
			off2_q <= `RST_BYTE;
		end else if (ce) begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr_q <= aoff;
			end
			if (addr_ok && !hwrite) begin
				hrdata <= {24'h000000, rd_mux};
			end
			if (wr_pend_q) begin
				case (wr_addr_q)
					// Plain storage, nothing else reads it
					`OFS_SCRATCH_BYTE: scratch_q <= hwdata[7:0];
					`OFS_EXT_FEATURE: efc_q <= hwdata[7:0];
					// Enhanced fields held unless unlocked
					`OFS_INT_MASK: imask_q <= merge_wr(imask_q, hwdata[7:0], 8'hf0, enh);
					`OFS_QUEUE_CONTROL: qctl_q <= merge_wr(qctl_q, hwdata[7:0], 8'h30, enh);
					`OFS_MODEM_OUT_CONTROL: moc_q <= merge_wr(moc_q, hwdata[7:0], 8'he0, enh);
					`OFS_RESUME_FIRST: on1_q <= hwdata[7:0];
					`OFS_RESUME_SECOND: on2_q <= hwdata[7:0];
					`OFS_PAUSE_FIRST: off1_q <= hwdata[7:0];
					`OFS_PAUSE_SECOND: off2_q <= hwdata[7:0];
					default: scratch_q <= scratch_q;
				endcase
			end
		end
	end
	// ****************************************
	// Modem change flags
	// ****************************************
	// Flags set on change, cleared by status read, set wins
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= 4'hf;
			primed_q <= 1'b0;
			delta_q <= 4'h0;
		end else if (ce) begin
			prev_q <= pins_q;
			primed_q <= 1'b1;
			if (addr_ok && !hwrite && aoff == `OFS_MODEM_LINE_STATE) begin
				// Side effect of the status read
				delta_q <= 4'h0;
			end
			if (primed_q) begin
				// Clear-to-send, data-set-ready and carrier: any change
				if (pins_q[0] != prev_q[0]) delta_q[0] <= 1'b1;
				if (pins_q[1] != prev_q[1]) delta_q[1] <= 1'b1;
				if (pins_q[3] != prev_q[3]) delta_q[3] <= 1'b1;
				// Ring: input pin rising only
				if (pins_q[2] && !prev_q[2]) delta_q[2] <= 1'b1;
			end
		end
	end
	// ****************************************
	// Interrupt cause flags
	// ****************************************
	// Bit 4 special character, bit 5 trigger reached; read clears, set wins
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_q <= 2'b00;
		end else if (ce) begin
			if (addr_ok && !hwrite && aoff == `OFS_INT_CAUSE) begin
				cause_q <= 2'b00;
			end
			if (wr_pend_q && wr_addr_q == `OFS_INT_CAUSE && enh) begin
				// Software access to the enhanced cause bits
				cause_q <= hwdata[5:4];
			end
			// Match on the second pause character
			if (efc_q[`EFC_SPECIAL] && rx_valid && rx_char == off2_q) begin
				cause_q[0] <= 1'b1;
			end
			// Trigger level reached under auto request-to-send
			if (efc_q[`EFC_AUTO_RTS] && at_trig) begin
				cause_q[1] <= 1'b1;
			end
		end
	end
	// ****************************************
	// Hardware flow control and outputs
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rts_n <= `RST_PIN_HIGH;
			tx_hold <= 1'b0;
			paused_q <= 1'b0;
			modem_irq <= 1'b0;
			rx_trigger_irq <= 1'b0;
			special_char_irq <= 1'b0;
		end else if (ce) begin
			if (efc_q[`EFC_AUTO_RTS]) begin
				// Deassert at next level, reassert below lower level
				if (at_next) begin
					rts_n <= 1'b1;
				end else if (below_lower) begin
					rts_n <= 1'b0;
				end
			end else begin
				// Ordinary modem control setting
				rts_n <= ~moc_q[`MOC_RTS];
			end
			// Pause on pause match, release on resume match
			if (efc_q[1:0] == `SEL_NONE) begin
				paused_q <= 1'b0;
			end else if (off_hit) begin
				paused_q <= 1'b1;
			end else if (on_hit) begin
				paused_q <= 1'b0;
			end
			// Clear-to-send pin high stops the transmitter
			tx_hold <= (efc_q[`EFC_AUTO_CTS] && pins_q[0]) || paused_q;
			// Any delta flag raises the modem interrupt
			modem_irq <= |delta_q;
			rx_trigger_irq <= enh && cause_q[1];
			special_char_irq <= enh && cause_q[0];
		end
	end
	// ****************************************
	// Software flow character sender
	// ****************************************
	// Sends pause near full and resume once space returns
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_IDLE;
			send_off_q <= 1'b0;
			sent_off_q <= 1'b0;
			tx_flow_req <= 1'b0;
			tx_flow_char <= 8'h00;
		end else if (ce) begin
			case (st_q)
				ST_IDLE: begin
					if (txsel == `SEL_NONE) begin
						sent_off_q <= 1'b0;
					end else if ((at_next && !sent_off_q) || (sent_off_q && below_lower)) begin
						send_off_q <= !sent_off_q;
						tx_flow_req <= 1'b1;
						st_q <= ST_FIRST;
						// Selection 01 sends second only, else first leads
						if (txsel == `SEL_SECOND) begin
							tx_flow_char <= sent_off_q ? on2_q : off2_q;
						end else begin
							tx_flow_char <= sent_off_q ? on1_q : off1_q;
						end
					end
				end
				ST_FIRST: begin
					if (tx_flow_ack) begin
						if (txsel == `SEL_BOTH) begin
							// Second character follows directly
							tx_flow_char <= send_off_q ? off2_q : on2_q;
							st_q <= ST_SECOND;
						end else begin
							tx_flow_req <= 1'b0;
							sent_off_q <= send_off_q;
							st_q <= ST_IDLE;
						end
					end
				end
				ST_SECOND: begin
					if (tx_flow_ack) begin
						tx_flow_req <= 1'b0;
						sent_off_q <= send_off_q;
						st_q <= ST_IDLE;
					end
				end
				default: begin
					tx_flow_req <= 1'b0;
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### dv/uart_fc_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module uart_fc_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic rts_n,
	input wire logic tx_hold,
	input wire logic tx_flow_req,
	input wire logic [7:0] tx_flow_char,
	input wire logic tx_flow_ack,
	input wire logic modem_irq,
	input wire logic special_char_irq
);
	logic take; // Transfer taken at this edge
	logic w_q; // Write data phase pending
	logic [3:0] a_q; // Word index of that write
	logic [7:0] sh [0:15]; // Shadow of written bytes
	assign take = hsel && hready && htrans[1] && ce;
	// Shadow register writes as the bus carries them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w_q <= 1'b0;
			a_q <= 4'h0;
			for (int i = 0; i < 16; i++) begin
				sh[i] <= 8'h00;
			end
		end else if (ce) begin
			w_q <= take && hwrite;
			a_q <= haddr[5:2];
			if (w_q) begin
				sh[a_q] <= hwdata[7:0];
			end
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_status_rd;
		take && !hwrite && haddr[7:0] == 8'h00;
	endsequence
	sequence s_first_taken;
		tx_flow_req && tx_flow_ack && sh[2][3:2] == 2'b11 && tx_flow_char == sh[9];
	endsequence
	property p_okay;
		hreadyout && !hresp;
	endproperty
	property p_delta_irq;
		$changed(cts_n) || $changed(dsr_n) |-> ##[1:6] modem_irq;
	endproperty
	property p_status_clr;
		s_status_rd |-> ##2 !modem_irq;
	endproperty
	property p_cts_hold;
		(sh[2][7] && sh[2][1:0] == 2'b00 && $stable(cts_n))[*6] |-> tx_hold == cts_n;
	endproperty
	property p_rts_man;
		(!sh[2][6] && $stable(sh[6][1]))[*4] |-> rts_n == !sh[6][1];
	endproperty
	property p_special;
		rx_valid && rx_char == sh[10] && sh[2][5:4] == 2'b11 |-> ##[1:3] special_char_irq;
	endproperty
	property p_stand;
		tx_flow_req && !tx_flow_ack |=> tx_flow_req && $stable(tx_flow_char);
	endproperty
	property p_pair;
		s_first_taken |=> tx_flow_req && tx_flow_char == sh[10];
	endproperty
	property p_sel_none;
		$rose(tx_flow_req) |-> sh[2][3:2] != 2'b00;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
	a_delta_irq: assert property (p_delta_irq) else $error("modem change raised no irq");
	a_status_clr: assert property (p_status_clr) else $error("status read left modem irq");
	a_cts_hold: assert property (p_cts_hold) else $error("hold does not follow cts");
	a_rts_man: assert property (p_rts_man) else $error("rts does not follow control");
	a_special: assert property (p_special) else $error("special character missed");
	a_stand: assert property (p_stand) else $error("flow offer dropped early");
	a_pair: assert property (p_pair) else $error("second pair char not offered");
	a_sel_none: assert property (p_sel_none) else $error("flow char with no selection");
endmodule
bind uart_flow_control_enhanced uart_fc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .cts_n(cts_n), .dsr_n(dsr_n),
	.rx_valid(rx_valid), .rx_char(rx_char), .rts_n(rts_n), .tx_hold(tx_hold),
	.tx_flow_req(tx_flow_req), .tx_flow_char(tx_flow_char), .tx_flow_ack(tx_flow_ack),
	.modem_irq(modem_irq), .special_char_irq(special_char_irq));
`default_nettype wire

// ### dv/peer_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Modem and link peer
// ****************************************
module peer_model (
	input wire logic hclk,
	input wire logic tx_flow_req,
	input wire logic [7:0] tx_flow_char,
	output logic cts_n,
	output logic dsr_n,
	output logic dcd_n,
	output logic ri_n,
	output logic rx_valid,
	output logic [7:0] rx_char,
	output logic [4:0] rx_level,
	output logic tx_flow_ack
);
	logic [2:0] wait_q = 3'h0; // Cycles the offer has stood
	logic [2:0] ack_wait = 3'h0; // Answer delay, set by the bench
	logic [7:0] got[$]; // Flow characters taken, in order
	initial begin
		{cts_n, dsr_n, dcd_n, ri_n} = 4'hf;
		rx_valid = 1'b0;
		rx_char = 8'h00;
		rx_level = 5'h00;
		tx_flow_ack = 1'b0;
	end
	// Take an offer once it has stood ack_wait cycles
	always @(posedge hclk) begin
		tx_flow_ack <= 1'b0;
		wait_q <= (tx_flow_req && !tx_flow_ack) ? wait_q + 3'h1 : 3'h0;
		if (tx_flow_req && !tx_flow_ack && wait_q >= ack_wait) begin
			tx_flow_ack <= 1'b1;
			got.push_back(tx_flow_char);
		end
	end
	// Modem pins change just after an edge
	task set_pins(input logic c, input logic d);
		@(posedge hclk);
		cts_n <= c;
		dsr_n <= d;
	endtask
	// Carrier and ring pins change just after an edge
	task set_aux(input logic cd, input logic r);
		@(posedge hclk);
		dcd_n <= cd;
		ri_n <= r;
	endtask
	// One received byte, rx_valid high for a single cycle
	task send_char(input logic [7:0] c);
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_char <= c;
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_char <= ~c; // Lane shows no stale byte
	endtask
	// Receive queue fill level
	task set_level(input logic [4:0] n);
		@(posedge hclk);
		rx_level <= n;
	endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic hclk = 1'b0; // 50 MHz clock
	logic hresetn, ce, hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, cts_n, dsr_n, dcd_n, ri_n, rts_n, rx_valid, tx_hold;
	logic tx_flow_req, tx_flow_ack, modem_irq, rx_trigger_irq, special_char_irq;
	logic [7:0] rx_char, tx_flow_char;
	logic [4:0] rx_level;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	always #10 hclk = ~hclk;
	assign hready = hreadyout;
	uart_flow_control_enhanced u_uart_flow_control_enhanced (.hclk(hclk), .hresetn(hresetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .rts_n(rts_n),
		.rx_valid(rx_valid), .rx_char(rx_char), .rx_level(rx_level), .tx_hold(tx_hold),
		.tx_flow_req(tx_flow_req), .tx_flow_char(tx_flow_char), .tx_flow_ack(tx_flow_ack),
		.modem_irq(modem_irq), .rx_trigger_irq(rx_trigger_irq),
		.special_char_irq(special_char_irq));
	peer_model u_peer_model (.hclk(hclk), .tx_flow_req(tx_flow_req),
		.tx_flow_char(tx_flow_char), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n),
		.rx_valid(rx_valid), .rx_char(rx_char), .rx_level(rx_level), .tx_flow_ack(tx_flow_ack));
	// ****************************************
	// Shared tasks
	// ****************************************
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One single AHB transfer; waits for hready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		check($sformatf("reg %h", a), r, {24'h0, e});
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		rd(8'h04, 8'hff);
		rd(8'h08, 8'h00);
		rd(8'h00, 8'h00);
		check("rts_n", rts_n, 1);
		wr(8'h3c, 8'h5a);
		rd(8'h3c, 8'h00);
	endtask
	task t_scratch;
		wr(8'h04, 8'ha5);
		rd(8'h04, 8'ha5);
		wr(8'h04, 8'h5a);
		rd(8'h04, 8'h5a);
		rd(8'h08, 8'h00);
		// Clock enable low: a write in that time must not land
		ce <= 1'b0;
		wr(8'h04, 8'h3c);
		ce <= 1'b1;
		rd(8'h04, 8'h5a);
	endtask
	task t_modem;
		u_peer_model.set_pins(1'b0, 1'b1);
		repeat (10) @(posedge hclk);
		check("modem_irq", modem_irq, 1);
		rd(8'h00, 8'h11);
		rd(8'h00, 8'h10);
		check("modem_irq", modem_irq, 0);
		u_peer_model.set_pins(1'b0, 1'b0);
		repeat (10) @(posedge hclk);
		rd(8'h00, 8'h32);
		u_peer_model.set_pins(1'b1, 1'b1);
		repeat (10) @(posedge hclk);
		rd(8'h00, 8'h03);
		rd(8'h00, 8'h00);
		// Carrier change and ring falling: only the carrier flag sets
		u_peer_model.set_aux(1'b0, 1'b0);
		repeat (10) @(posedge hclk);
		check("modem_irq", modem_irq, 1);
		rd(8'h00, 8'hc8);
		u_peer_model.set_aux(1'b1, 1'b1);
		repeat (10) @(posedge hclk);
		rd(8'h00, 8'h0c);
		rd(8'h00, 8'h00);
	endtask
	task t_auto_cts;
		wr(8'h08, 8'h80);
		repeat (8) @(posedge hclk);
		check("tx_hold", tx_hold, 1);
		u_peer_model.set_pins(1'b0, 1'b1);
		repeat (8) @(posedge hclk);
		check("tx_hold", tx_hold, 0);
		u_peer_model.set_pins(1'b1, 1'b1);
		repeat (8) @(posedge hclk);
		check("tx_hold", tx_hold, 1);
		wr(8'h08, 8'h00);
		rd(8'h00, 8'h01);
	endtask
	task t_rts;
		wr(8'h18, 8'h02);
		repeat (4) @(posedge hclk);
		check("rts_n", rts_n, 0);
		wr(8'h08, 8'h50);
		u_peer_model.set_level(5'h03);
		repeat (4) @(posedge hclk);
		check("rts_n", rts_n, 0);
		check("rx_trigger_irq", rx_trigger_irq, 1);
		u_peer_model.set_level(5'h04);
		repeat (4) @(posedge hclk);
		check("rts_n", rts_n, 1);
		u_peer_model.set_level(5'h01);
		repeat (4) @(posedge hclk);
		check("rts_n", rts_n, 1);
		u_peer_model.set_level(5'h00);
		repeat (4) @(posedge hclk);
		check("rts_n", rts_n, 0);
		wr(8'h08, 8'h00);
		wr(8'h18, 8'h00);
		repeat (4) @(posedge hclk);
		check("rts_n", rts_n, 1);
		check("rx_trigger_irq", rx_trigger_irq, 0);
	endtask
	task t_special;
		logic [31:0] r;
		wr(8'h28, 8'h13);
		wr(8'h08, 8'h30); // Selection bits left clear
		u_peer_model.send_char(8'h12);
		repeat (4) @(posedge hclk);
		check("special_char_irq", special_char_irq, 0);
		u_peer_model.send_char(8'h13);
		repeat (4) @(posedge hclk);
		check("special_char_irq", special_char_irq, 1);
		bus(1'b0, 8'h10, 8'h00, r);
		check("cause special", r[4], 1);
		wr(8'h08, 8'h00);
	endtask
	task t_gate;
		logic [7:0] a, m;
		for (int i = 0; i < 3; i++) begin
			a = (i == 2) ? 8'h14 : (i ? 8'h18 : 8'h0c);
			m = (i == 2) ? 8'h30 : (i ? 8'he0 : 8'hf0);
			wr(8'h08, 8'h10);
			wr(a, m | 8'h01);
			rd(a, m | 8'h01);
			wr(8'h08, 8'h00);
			rd(a, 8'h01);
			wr(a, m);
			rd(a, 8'h00);
			wr(8'h08, 8'h10);
			rd(a, m);
			wr(a, 8'h00);
			wr(8'h08, 8'h00);
		end
	endtask
	task t_tx_flow;
		logic [7:0] ex[$];
		logic [1:0] c;
		wr(8'h1c, 8'h11);
		wr(8'h20, 8'h22);
		wr(8'h24, 8'h33);
		wr(8'h28, 8'h44);
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			ex = {};
			if (c[1]) ex.push_back(8'h33);
			if (c[0]) ex.push_back(8'h44);
			if (c[1]) ex.push_back(8'h11);
			if (c[0]) ex.push_back(8'h22);
			u_peer_model.ack_wait = {1'b0, c};
			wr(8'h08, {4'h0, c, 2'b00});
			u_peer_model.got.delete();
			u_peer_model.set_level(5'h04);
			repeat (20) @(posedge hclk);
			u_peer_model.set_level(5'h00);
			repeat (20) @(posedge hclk);
			check("flow count", u_peer_model.got.size(), ex.size());
			foreach (ex[k]) check("flow char", u_peer_model.got[k], ex[k]);
		end
	endtask
	task t_rx_flow;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(8'h08, {6'h00, c});
			if (c[1]) u_peer_model.send_char(8'h33);
			if (c[0]) u_peer_model.send_char(8'h44);
			repeat (4) @(posedge hclk);
			check("tx_hold", tx_hold, c != 2'b00);
			if (c[1]) u_peer_model.send_char(8'h11);
			if (c[0]) u_peer_model.send_char(8'h22);
			repeat (4) @(posedge hclk);
			check("tx_hold", tx_hold, 0);
		end
	endtask
	// Cut a hung run short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out;
		end
	end
	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_scratch;
		t_modem;
		t_auto_cts;
		t_rts;
		t_special;
		t_gate;
		t_tx_flow;
		t_rx_flow;
		close_out;
	end
endmodule
`default_nettype wire
